/* uhp_params.svh */
// Constants for the host parallel port of the USB peripheral controller.
// Assumes inclusion by the package and the design modules only.
`ifndef UHP_PARAMS_SVH
`define UHP_PARAMS_SVH

`define UHP_DATA_W 8
`define UHP_SYNC_W 5
`define UHP_POR_TIME_NS 1000
`define UHP_CLK_PERIOD_NS 25
`define UHP_POR_CYCLES ((`UHP_POR_TIME_NS + `UHP_CLK_PERIOD_NS - 1) / `UHP_CLK_PERIOD_NS)
`define UHP_POR_CNT_W 6
`define UHP_SEL_CMD 1'b1
`define UHP_SEL_DATA 1'b0

`endif

/* uhp_pkg.sv */
// Types shared by the host parallel port modules.
// Assumes uhp_params.svh is on the include path.
`default_nettype none
`include "uhp_params.svh"

package uhp_pkg;

    // Synchronised host strobes, all active low except ale
    typedef struct packed {
        logic cs_n;
        logic rd_n;
        logic wr_n;
        logic grant_n;
        logic term_n;
        logic ale;
    } uhp_strobes_t;

    // One decoded access handed to the core
    typedef struct packed {
        logic is_cmd;
        logic is_write;
        logic [`UHP_DATA_W-1:0] data;
    } uhp_access_t;

    // Bus phase state
    typedef enum logic [2:0] {
        UHP_IDLE = 3'b001,
        UHP_RD = 3'b010,
        UHP_WR = 3'b100
    } uhp_state_t;

endpackage : uhp_pkg

`default_nettype wire

/* uhp_sync.sv */
// Three-stage synchroniser with agreement filter for one pin input.
// Assumes the input is asynchronous to ref_clk_i.
`timescale 1ns/100ps
`default_nettype none

module uhp_sync (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    // Pin and filtered level
    input wire logic pin_i,
    input wire logic rst_val_i,
    output logic level_o
);
    logic s1;
    logic s2;
    logic s3;

    // Chain; only s2 reads s1
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s1 <= 1'b1;
            s2 <= 1'b1;
            s3 <= 1'b1;
        end else begin
            s1 <= pin_i;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // Change counts once stages two and three agree
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            level_o <= 1'b1;
        end else if (s2 == s3) begin
            level_o <= s2;
        end
    end

    logic unused;
    assign unused = rst_val_i;

endmodule : uhp_sync

`default_nettype wire

/* uhp_host_port.sv */
// Host-side parallel port: strobe decode, address latch, DMA termination, suspend and interrupt pins.
// Assumes an external microcontroller or DMA controller drives the strobes asynchronously.
`timescale 1ns/100ps
`default_nettype none
`include "uhp_params.svh"

module uhp_host_port
    import uhp_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    // Host strobes
    input wire logic cs_low_i,
    input wire logic rd_low_i,
    input wire logic wr_low_i,
    input wire logic ale_i,
    input wire logic cmd_data_select_i,
    input wire logic mux_mode_i,
    // Data bus pins
    input wire logic [`UHP_DATA_W-1:0] data_i,
    output logic [`UHP_DATA_W-1:0] data_o,
    output logic data_oe_o,
    // DMA pins
    input wire logic dma_grant_low_i,
    input wire logic dma_term_low_i,
    // Core side
    input wire logic [`UHP_DATA_W-1:0] rd_data_i,
    input wire logic irq_i,
    input wire logic usb_suspend_i,
    input wire logic suspend_pin_i,
    output uhp_access_t acc_o,
    output logic acc_valid_o,
    output logic dma_done_o,
    output logic test_mode_o,
    // Status pins
    output logic int_low_o,
    output logic suspend_o,
    output logic suspend_oe_o
);
    uhp_strobes_t stb;
    uhp_state_t state;
    logic por_done;
    logic [`UHP_POR_CNT_W-1:0] por_cnt;
    logic ale_q;
    logic addr_latch;
    logic [`UHP_DATA_W-1:0] data_s;
    logic sel_s;
    logic cs_at_reset;
    logic core_rstn;
    logic susp_in_s;

    // Cycles of the power-on window before its last one
    localparam int POR_HOLD = `UHP_POR_CYCLES - 1;

    // Synchronise each asynchronous control pin
    uhp_sync u_cs (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .pin_i(cs_low_i), .rst_val_i(1'b1), .level_o(stb.cs_n));
    uhp_sync u_rd (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .pin_i(rd_low_i), .rst_val_i(1'b1), .level_o(stb.rd_n));
    uhp_sync u_wr (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .pin_i(wr_low_i), .rst_val_i(1'b1), .level_o(stb.wr_n));
    uhp_sync u_gr (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .pin_i(dma_grant_low_i), .rst_val_i(1'b1),
                   .level_o(stb.grant_n));
    uhp_sync u_tm (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .pin_i(dma_term_low_i), .rst_val_i(1'b1),
                   .level_o(stb.term_n));
    uhp_sync u_al (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .pin_i(ale_i), .rst_val_i(1'b1), .level_o(stb.ale));
    uhp_sync u_sl (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .pin_i(cmd_data_select_i), .rst_val_i(1'b1),
                   .level_o(sel_s));
    uhp_sync u_sp (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .pin_i(suspend_pin_i), .rst_val_i(1'b1),
                   .level_o(susp_in_s));

    // Data sampled every cycle through one register
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            data_s <= '0;
        end else begin
            data_s <= data_i;
        end
    end

    // Power-on reset counter; started only by a release of the reset pin
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            por_cnt <= '0;
            por_done <= 1'b0;
        end else if (!por_done) begin
            por_cnt <= por_cnt + `UHP_POR_CNT_W'(1);
            por_done <= (por_cnt == `UHP_POR_CNT_W'(`UHP_POR_CYCLES - 1));
        end
    end
    assign core_rstn = rstn_i & por_done;

    // Catch chip select low in any but the last cycle of the power-on window for test-mode entry
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cs_at_reset <= 1'b0;
            test_mode_o <= 1'b0;
        end else if (!por_done) begin
            cs_at_reset <= cs_at_reset | ~stb.cs_n;
            test_mode_o <= cs_at_reset;
        end
    end

    // Address latch on falling edge of ALE in multiplexed mode
    always_ff @(posedge ref_clk_i or negedge core_rstn) begin
        if (!core_rstn) begin
            ale_q <= 1'b0;
            addr_latch <= `UHP_SEL_DATA;
        end else begin
            ale_q <= stb.ale;
            if (mux_mode_i && ale_q && !stb.ale) begin
                addr_latch <= data_s[0];
            end
        end
    end

    // Access state machine on active-low strobes
    always_ff @(posedge ref_clk_i or negedge core_rstn) begin
        if (!core_rstn) begin
            state <= UHP_IDLE;
            acc_valid_o <= 1'b0;
            acc_o <= '0;
        end else begin
            acc_valid_o <= 1'b0;
            case (state)
                UHP_IDLE: begin
                    if (!stb.cs_n && !stb.rd_n) begin
                        state <= UHP_RD;
                        acc_valid_o <= 1'b1;
                        acc_o.is_write <= 1'b0;
                        acc_o.is_cmd <= mux_mode_i ? addr_latch : sel_s;
                        acc_o.data <= '0;
                    end else if (!stb.cs_n && !stb.wr_n) begin
                        state <= UHP_WR;
                    end
                end
                UHP_RD: begin
                    if (stb.rd_n) begin
                        state <= UHP_IDLE;
                    end
                end
                UHP_WR: begin
                    if (stb.wr_n) begin
                        state <= UHP_IDLE;
                        acc_valid_o <= 1'b1;
                        acc_o.is_write <= 1'b1;
                        acc_o.is_cmd <= mux_mode_i ? addr_latch : sel_s;
                        acc_o.data <= data_s;
                    end
                end
                default: begin
                    state <= UHP_IDLE;
                end
            endcase
        end
    end

    // Drive data bus only during a selected read
    always_ff @(posedge ref_clk_i or negedge core_rstn) begin
        if (!core_rstn) begin
            data_o <= '0;
            data_oe_o <= 1'b0;
        end else begin
            data_oe_o <= !stb.cs_n && !stb.rd_n;
            data_o <= rd_data_i;
        end
    end

    // Termination qualified by grant and a strobe
    always_ff @(posedge ref_clk_i or negedge core_rstn) begin
        if (!core_rstn) begin
            dma_done_o <= 1'b0;
        end else begin
            dma_done_o <= !stb.term_n && !stb.grant_n && (!stb.rd_n || !stb.wr_n);
        end
    end

    // Interrupt and suspend pins
    always_ff @(posedge ref_clk_i or negedge core_rstn) begin
        if (!core_rstn) begin
            int_low_o <= 1'b1;
            suspend_o <= 1'b0;
            suspend_oe_o <= 1'b0;
        end else begin
            int_low_o <= ~irq_i;
            suspend_o <= 1'b1;
            suspend_oe_o <= usb_suspend_i;
        end
    end

    logic unused;
    assign unused = susp_in_s;

    // Termination pulse only with grant and strobe
    AST_TERM_QUAL: assert property (@(posedge ref_clk_i) disable iff (!core_rstn)
        dma_done_o |-> $past(!stb.grant_n && (!stb.rd_n || !stb.wr_n)))
        else $error("termination accepted without grant and strobe");
    AST_TERM_IGN: assert property (@(posedge ref_clk_i) disable iff (!core_rstn)
        $past(stb.grant_n) |-> !dma_done_o)
        else $error("termination accepted without grant");
    // Kind of each access, checked at read decode and at write completion
    AST_SEL_CMD: assert property (@(posedge ref_clk_i) disable iff (!core_rstn)
        (!mux_mode_i && ((state == UHP_IDLE && !stb.cs_n && !stb.rd_n) || (state == UHP_WR && stb.wr_n)))
        |=> (acc_o.is_cmd == $past(sel_s)))
        else $error("select bit not honoured");
    AST_MUX_IGN: assert property (@(posedge ref_clk_i) disable iff (!core_rstn)
        (mux_mode_i && ((state == UHP_IDLE && !stb.cs_n && !stb.rd_n) || (state == UHP_WR && stb.wr_n)))
        |=> (acc_o.is_cmd == $past(addr_latch)))
        else $error("select bit used in multiplexed mode");
    // Power-on window runs its full length after every reset release
    AST_POR: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        $rose(rstn_i) |-> !por_done ##POR_HOLD !por_done ##1 por_done)
        else $error("power-on window has the wrong length");
    // Pins follow the core, and the bus enable the read strobes, one cycle later, once the core has left reset
    AST_SUSP: assert property (@(posedge ref_clk_i) disable iff (!core_rstn)
        (usb_suspend_i && $past(core_rstn)) |=> suspend_oe_o)
        else $error("suspend not shown");
    AST_INT: assert property (@(posedge ref_clk_i) disable iff (!core_rstn)
        (irq_i && $past(core_rstn)) |=> !int_low_o)
        else $error("interrupt not driven low");
    AST_RD_OE: assert property (@(posedge ref_clk_i) disable iff (!core_rstn)
        data_oe_o |-> $past(!stb.cs_n && !stb.rd_n))
        else $error("bus driven outside read");

endmodule : uhp_host_port

`default_nettype wire

/* uhp_host_model.sv */
// Host microcontroller model driving the strobes of the parallel port.
// Assumes the testbench calls access and latch after reset, hold_select also during reset, and supplies the clock.
`timescale 1ns/100ps
`default_nettype none

module uhp_host_model (
    // Clock
    input wire logic ref_clk_i,
    // Strobes and bus toward the port
    output logic cs_low_o,
    output logic rd_low_o,
    output logic wr_low_o,
    output logic ale_o,
    output logic sel_o,
    output logic grant_low_o,
    output logic term_low_o,
    output logic [7:0] data_o
);
    // Idle: strobes high except ale, select high, bus shows a stale pattern
    initial begin
        {cs_low_o, rd_low_o, wr_low_o, grant_low_o, term_low_o, sel_o} = 6'h3f;
        ale_o = 1'b0;
        data_o = 8'ha5;
    end

    // One access; only called with reset released, never while hold_select holds chip select low
    task automatic access(input logic cs, input logic rd, input logic wr, input logic sel,
                          input logic [7:0] d, input logic gnt, input logic trm);
        @(negedge ref_clk_i);
        {cs_low_o, rd_low_o, wr_low_o, sel_o, data_o} = {cs, rd, wr, sel, d};
        {grant_low_o, term_low_o} = {gnt, trm};
        repeat (8) @(negedge ref_clk_i);
        {rd_low_o, wr_low_o, grant_low_o, term_low_o} = 4'hf;
        repeat (2) @(negedge ref_clk_i);
        cs_low_o = 1'b1;
        // Byte held past the port's late sample of the write data
        repeat (6) @(negedge ref_clk_i);
        data_o = ~d; // Released bus no longer shows the byte
        repeat (2) @(negedge ref_clk_i);
    endtask : access

    // Chip select level held outside any access
    task automatic hold_select(input logic v);
        @(negedge ref_clk_i);
        cs_low_o = v;
    endtask : hold_select

    // Address phase on the shared bus, closed by the falling latch edge
    task automatic latch(input logic [7:0] a);
        @(negedge ref_clk_i);
        data_o = a;
        ale_o = 1'b1;
        repeat (6) @(negedge ref_clk_i);
        ale_o = 1'b0;
        repeat (6) @(negedge ref_clk_i);
        data_o = ~a;
    endtask : latch
endmodule : uhp_host_model

`default_nettype wire

/* tb.sv */
// Self-checking testbench for the host parallel port.
// Assumes uhp_pkg and the host model are compiled first.
`timescale 1ns/100ps
`default_nettype none

module tb;
    import uhp_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic ref_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic mux_mode = 1'b0;
    logic irq = 1'b0;
    logic usb_susp = 1'b0;
    logic cs, rd, wr, ale, sel, gnt, trm, data_oe, acc_valid, dma_done, test_mode, int_low, susp, susp_oe;
    logic [7:0] hdata, ddata, bus;
    uhp_access_t acc, acc_seen;
    int n_errors = 0;
    int samples_checked = 0;
    int n_acc = 0;
    int n_done = 0;

    // Clock and wire levels; the suspend pin has a pull-up
    always #12.5 ref_clk_i = ~ref_clk_i;
    assign bus = data_oe ? ddata : hdata;

    uhp_host_model host (.ref_clk_i(ref_clk_i), .cs_low_o(cs), .rd_low_o(rd), .wr_low_o(wr), .ale_o(ale),
        .sel_o(sel), .grant_low_o(gnt), .term_low_o(trm), .data_o(hdata));

    uhp_host_port dut (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .cs_low_i(cs), .rd_low_i(rd), .wr_low_i(wr),
        .ale_i(ale), .cmd_data_select_i(sel), .mux_mode_i(mux_mode), .data_i(bus), .data_o(ddata),
        .data_oe_o(data_oe), .dma_grant_low_i(gnt), .dma_term_low_i(trm), .rd_data_i(8'h5a), .irq_i(irq),
        .usb_suspend_i(usb_susp), .suspend_pin_i(susp_oe ? susp : 1'b1), .acc_o(acc),
        .acc_valid_o(acc_valid), .dma_done_o(dma_done), .test_mode_o(test_mode), .int_low_o(int_low),
        .suspend_o(susp), .suspend_oe_o(susp_oe));

    // Capture one-cycle access pulses and count termination cycles where they are settled
    always @(negedge ref_clk_i) begin
        if (acc_valid === 1'b1) begin
            acc_seen = acc;
            n_acc++;
        end
        if (dma_done === 1'b1) n_done++;
    end

    // ------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic complete_run();
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : complete_run

    // Reset pulse, then wait out the power-on window and synchroniser
    task automatic do_reset();
        @(negedge ref_clk_i);
        rstn_i = 1'b0;
        #1;
        check({int_low, data_oe, susp_oe, test_mode}, 4'h8);
        repeat (16) @(negedge ref_clk_i);
        rstn_i = 1'b1;
        repeat (60) @(negedge ref_clk_i);
        check(test_mode, 1'b0);
    endtask : do_reset

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Write with select value, expect one access of the kind exp_cmd
    task automatic t_write(input logic s, input logic [7:0] d, input logic exp_cmd);
        int n0;
        n0 = n_acc;
        host.access(1'b0, 1'b1, 1'b0, s, d, 1'b1, 1'b1);
        check(n_acc, n0 + 1);
        check(acc_seen, {exp_cmd, 1'b1, d});
    endtask : t_write

    task automatic t_read_and_nocs();
        int n0;
        n0 = n_acc;
        fork
            host.access(1'b0, 1'b0, 1'b1, 1'b0, 8'hff, 1'b1, 1'b1);
            begin
                repeat (7) @(negedge ref_clk_i);
                check({data_oe, ddata}, {1'b1, 8'h5a});
            end
        join
        check(n_acc, n0 + 1);
        check(acc_seen.is_write, 1'b0);
        check(data_oe, 1'b0);
        n0 = n_acc;
        host.access(1'b1, 1'b0, 1'b0, 1'b1, 8'h33, 1'b1, 1'b1);
        check(n_acc, n0);
    endtask : t_read_and_nocs

    task automatic t_dma();
        host.access(1'b0, 1'b1, 1'b0, 1'b0, 8'h11, 1'b1, 1'b0);
        host.access(1'b0, 1'b1, 1'b1, 1'b0, 8'h12, 1'b0, 1'b0);
        check(n_done, 0);
        host.access(1'b0, 1'b1, 1'b0, 1'b0, 8'h13, 1'b0, 1'b0);
        check(n_done > 0, 1'b1);
    endtask : t_dma

    task automatic t_mux();
        mux_mode = 1'b1;
        host.latch(8'h00);
        t_write(1'b1, 8'hc3, 1'b0);
        host.latch(8'h01);
        t_write(1'b1, 8'h3c, 1'b1);
        mux_mode = 1'b0;
    endtask : t_mux

    task automatic t_status();
        irq = 1'b1;
        usb_susp = 1'b1;
        repeat (10) @(negedge ref_clk_i);
        check({int_low, susp_oe, susp}, 3'h3);
        do_reset(); // Mid-run reset with both levels raised
        irq = 1'b0;
        usb_susp = 1'b0;
        repeat (10) @(negedge ref_clk_i);
        check({int_low, susp_oe}, 2'h2);
    endtask : t_status

    // Select held low across reset puts the port in test mode
    task automatic t_test_mode();
        @(negedge ref_clk_i);
        rstn_i = 1'b0;
        host.hold_select(1'b0);
        repeat (16) @(negedge ref_clk_i);
        rstn_i = 1'b1;
        repeat (60) @(negedge ref_clk_i);
        check(test_mode, 1'b1);
        host.hold_select(1'b1);
        do_reset(); // Clean reset leaves test mode
    endtask : t_test_mode

    // Watchdog
    initial begin
        #(25 * 5000);
        n_errors++;
        complete_run();
    end

    initial begin
        do_reset();
        t_write(1'b1, 8'h81, 1'b1);
        t_write(1'b0, 8'h7e, 1'b0);
        t_read_and_nocs();
        t_dma();
        t_mux();
        t_status();
        t_test_mode();
        complete_run();
    end
endmodule : tb

`default_nettype wire
